// ==== ext_requesters.sv ====
// Behavioural model of the external requesters and the off-chip vector controller
`timescale 1ns/10ps
`default_nettype none
module ext_requesters (
  input wire logic clk,
  input wire logic exp_mode,
  input wire logic [7:0] line_req,
  input wire logic [7:0] vec,
  input wire logic nmi_req,
  output logic [7:0] irq_pins,
  output logic nmi_pin
);
  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Pins move on the falling edge so they land out of phase with the sampling edge
  always @(negedge clk) begin
    irq_pins <= exp_mode ? vec : line_req;
    nmi_pin <= nmi_req;
  end
endmodule
`default_nettype wire

// ==== external_interrupt_intake.sv ====
// Interrupt intake: pin detection, pending flags, priority, vector and halt wake-up
// Operation
// [RULE1] Dedicated requester toggles its own pin only
// [RULE2] Device assigns priority and vector, 240 vectors
// [RULE3] Per pin edge/level and fast/debounced sampling
// [RULE4] Expanded mode: external controller drives vector
// [RULE5] Eight external inputs, each individually maskable
// [RULE6] One extra input, never masked
// [RULE7] Two timers share the same priority logic
// [RULE8] Detection keeps running while core halted
// [RULE9] External or timer interrupt ends halt
// [RULE10] Wake resumes at handler of interrupt vector
// [RULE11] Expanded mode samples pin vector for priority
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "intake_regs.svh"
module external_interrupt_intake
  import intake_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire reg_req_t bus_req,
  output logic [31:0] rd_data_q,
  input wire logic [7:0] irq_pins,
  input wire logic nmi_pin,
  input wire logic [1:0] tmr_evt,
  input wire logic halt_enter,
  input wire logic int_ack,
  output irq_req_t core_irq_q,
  output logic irq_q,
  output logic wake_q,
  output logic halted_q
);

  // ----------------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------------
  logic [`NPINS-1:0] raw_pins, fast, deb;
  assign raw_pins = {nmi_pin, irq_pins};

  for (genvar i = 0; i < `NPINS; i++) begin : g_pin
    pin_sampler u_smp (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin(raw_pins[i]),
      .fast_q(fast[i]),
      .deb_q(deb[i])
    );
  end

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  logic exp_q, exp_d;
  logic [`NSRC-1:0] mask_q, mask_d;
  logic [15:0] trig_q, trig_d;
  logic [7:0] pvec_q [8];
  logic [7:0] pvec_d [8];
  logic [7:0] tvec_q [2];
  logic [7:0] tvec_d [2];
  logic wr_hit;

  assign wr_hit = ce && bus_req.wr;

  always_comb begin
    exp_d = exp_q;
    mask_d = mask_q;
    trig_d = trig_q;
    pvec_d = pvec_q;
    tvec_d = tvec_q;
    if (wr_hit) begin
      case (bus_req.addr)
        `OFF_CTRL: exp_d = bus_req.wdata[`CTRL_EXP_BIT]; // [RULE4]
        `OFF_MASK: begin
          mask_d = bus_req.wdata[`NSRC-1:0];
          mask_d[`SRC_NMI] = 1'b0; // [RULE6]
        end
        `OFF_TRIG: trig_d = bus_req.wdata[15:0]; // [RULE3]
        `OFF_VEC_LO: begin
          for (int k = 0; k < 4; k++) begin
            pvec_d[k] = bus_req.wdata[8*k +: 8];
          end
        end
        `OFF_VEC_HI: begin
          for (int k = 0; k < 4; k++) begin
            pvec_d[k+4] = bus_req.wdata[8*k +: 8];
          end
        end
        `OFF_TVEC: begin
          tvec_d[0] = bus_req.wdata[7:0];
          tvec_d[1] = bus_req.wdata[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exp_q <= `CTRL_RST;
      mask_q <= `MASK_RST & ~(`NSRC'(1) << `SRC_NMI);
      trig_q <= `TRIG_RST;
      pvec_q <= '{default: `VEC_RST};
      tvec_q <= '{default: `VEC_RST};
    end else if (ce) begin
      exp_q <= exp_d;
      mask_q <= mask_d;
      trig_q <= trig_d;
      pvec_q <= pvec_d;
      tvec_q <= tvec_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Event detection and pending flags
  // ----------------------------------------------------------------------------
  logic [`NPINS-1:0] sel, prev_q;
  logic [7:0] exp_prev_q, exp_vec_q, exp_vec_d;
  logic [`NSRC-1:0] ev, st_q, st_d, clr;
  logic exp_new;
  logic [3:0] src_q, src_d;

  always_comb begin
    // Debounce trades latency for immunity to glitches on slow board lines
    for (int i = 0; i < 8; i++) begin
      sel[i] = trig_q[`TRIG_DEB_LSB + i] ? deb[i] : fast[i]; // [RULE3]
    end
    sel[`SRC_NMI] = fast[`SRC_NMI];
    exp_new = exp_q && (fast[7:0] != exp_prev_q);
    ev = '0;
    // Each dedicated pin stands for one source; no vector comes from the requester
    for (int i = 0; i < 8; i++) begin
      ev[i] = !exp_q && (trig_q[i] ? (sel[i] && !prev_q[i]) : sel[i]); // [RULE1] [RULE3]
    end
    ev[`SRC_NMI] = sel[`SRC_NMI] && !prev_q[`SRC_NMI]; // [RULE6]
    ev[`SRC_TMR0] = tmr_evt[0]; // [RULE7]
    ev[`SRC_TMR1] = tmr_evt[1]; // [RULE7]
    ev[`SRC_EXP] = exp_new && (fast[7:0] >= `VEC_MIN) && (fast[7:0] <= `VEC_MAX); // [RULE11]
    exp_vec_d = ev[`SRC_EXP] ? fast[7:0] : exp_vec_q; // [RULE4]
    clr = '0;
    if (wr_hit && (bus_req.addr == `OFF_STATUS)) begin
      clr = bus_req.wdata[`NSRC-1:0];
    end
    if (int_ack && core_irq_q.valid) begin
      clr[src_q] = 1'b1;
    end
    // Set wins over clear so an event in the clearing cycle is kept; runs in halt too
    st_d = (st_q & ~clr) | ev; // [RULE8]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= '0;
      exp_prev_q <= 8'h00;
      exp_vec_q <= 8'h00;
      st_q <= '0;
    end else if (ce) begin
      prev_q <= sel;
      exp_prev_q <= fast[7:0];
      exp_vec_q <= exp_vec_d;
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------------------
  logic [7:0] src_vec [`NSRC];
  logic [`NSRC-1:0] elig;
  logic [7:0] best_vec;
  logic any;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      src_vec[i] = pvec_q[i];
    end
    src_vec[`SRC_NMI] = `NMI_VEC;
    src_vec[`SRC_TMR0] = tvec_q[0];
    src_vec[`SRC_TMR1] = tvec_q[1];
    src_vec[`SRC_EXP] = exp_vec_q;
    for (int s = 0; s < `NSRC; s++) begin
      // Unprogrammed vectors outside the 240-entry space never raise a request
      elig[s] = st_q[s] && !mask_q[s] && (src_vec[s] >= `VEC_MIN)
        && (src_vec[s] <= `VEC_MAX); // [RULE2] [RULE5]
    end
    elig[`SRC_NMI] = st_q[`SRC_NMI]; // [RULE6]
    best_vec = 8'h00;
    src_d = 4'h0;
    any = 1'b0;
    // Higher vector means higher priority; ties go to the lower source index
    for (int s = 0; s < `NSRC; s++) begin
      if (elig[s] && (!any || (src_vec[s] > best_vec))) begin
        any = 1'b1;
        best_vec = src_vec[s]; // [RULE2] [RULE7] [RULE11]
        src_d = 4'(s);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Halt state and core hand-off
  // ----------------------------------------------------------------------------
  core_state_t state_q, state_d;
  logic wake_d;
  logic [31:0] rd_d;

  always_comb begin
    state_d = state_q;
    wake_d = 1'b0;
    case (state_q)
      CORE_RUN: begin
        if (halt_enter) begin
          state_d = CORE_HALTED;
        end
      end
      CORE_HALTED: begin
        if (any) begin
          state_d = CORE_RUN; // [RULE9]
          wake_d = 1'b1; // [RULE10]
        end
      end
      default: state_d = CORE_RUN;
    endcase
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `OFF_CTRL: rd_d = {30'h0, halted_q, exp_q};
        `OFF_MASK: rd_d = {20'h0, mask_q};
        `OFF_TRIG: rd_d = {16'h0, trig_q};
        `OFF_VEC_LO: rd_d = {pvec_q[3], pvec_q[2], pvec_q[1], pvec_q[0]};
        `OFF_VEC_HI: rd_d = {pvec_q[7], pvec_q[6], pvec_q[5], pvec_q[4]};
        `OFF_TVEC: rd_d = {16'h0, tvec_q[1], tvec_q[0]};
        `OFF_STATUS: rd_d = {20'h0, st_q};
        `OFF_ACTIVE: rd_d = {19'h0, src_q, core_irq_q.valid, core_irq_q.vector};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CORE_RUN;
      wake_q <= 1'b0;
      halted_q <= 1'b0;
      core_irq_q <= '0;
      irq_q <= 1'b0;
      src_q <= 4'h0;
      rd_data_q <= 32'h0000_0000;
    end else if (ce) begin
      state_q <= state_d;
      wake_q <= wake_d;
      halted_q <= (state_d == CORE_HALTED);
      core_irq_q.valid <= any;
      core_irq_q.vector <= best_vec; // [RULE10]
      irq_q <= any;
      src_q <= src_d;
      rd_data_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_nmi_always_taken: assert property (ce && st_q[`SRC_NMI] |=> // [RULE6]
    core_irq_q.valid && (core_irq_q.vector == `NMI_VEC))
    else $error("pending non-maskable request not presented");
  chk_masked_silent: assert property (ce && (elig == '0) |=> !irq_q) // [RULE5]
    else $error("interrupt raised with nothing eligible");
  chk_vector_space: assert property (core_irq_q.valid |-> // [RULE2]
    (core_irq_q.vector >= `VEC_MIN) && (core_irq_q.vector <= `NMI_VEC))
    else $error("vector outside the vector space");
  chk_edge_sets_flag: assert property (ce && !exp_q && trig_q[0] && sel[0] && !prev_q[0] // [RULE3]
    |=> st_q[0])
    else $error("edge on pin 0 not latched");
  chk_level_sets_flag: assert property (ce && !exp_q && !trig_q[0] && sel[0] ##1 ce // [RULE3]
    |-> st_q[0])
    else $error("level on pin 0 not held pending");
  chk_timer_pending: assert property (ce && tmr_evt[1] |=> st_q[`SRC_TMR1]) // [RULE7]
    else $error("timer event lost");
  chk_halt_detects: assert property (ce && halted_q && tmr_evt[0] |=> st_q[`SRC_TMR0]) // [RULE8]
    else $error("detection stopped during halt");
  chk_halt_wakes: assert property (ce && (state_q == CORE_HALTED) && any // [RULE9]
    |=> wake_q && !halted_q)
    else $error("pending interrupt did not end halt");
  chk_wake_vector: assert property (wake_q |-> core_irq_q.valid && irq_q) // [RULE10]
    else $error("wake without a vector for the handler");
  chk_exp_vector: assert property (ce && ev[`SRC_EXP] |=> // [RULE11]
    st_q[`SRC_EXP] && (exp_vec_q == $past(fast[7:0])))
    else $error("expanded vector not captured");

  cov_wake: cover property (ce && (state_q == CORE_HALTED) ##1 wake_q);
  cov_nmi: cover property (core_irq_q.valid && (core_irq_q.vector == `NMI_VEC));
  cov_exp: cover property (ce && ev[`SRC_EXP] ##1 core_irq_q.valid);

endmodule
`default_nettype wire

// ==== intake_pkg.sv ====
// Types shared by the interrupt intake modules
`default_nettype none
`include "intake_regs.svh"
package intake_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } irq_req_t;

  typedef enum {CORE_RUN, CORE_HALTED} core_state_t;

endpackage
`default_nettype wire

// ==== intake_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the interrupt intake
`ifndef INTAKE_REGS_SVH
`define INTAKE_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_MASK 8'h04
`define OFF_TRIG 8'h08
`define OFF_VEC_LO 8'h0c
`define OFF_VEC_HI 8'h10
`define OFF_TVEC 8'h14
`define OFF_STATUS 8'h18
`define OFF_ACTIVE 8'h1c

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_EXP_BIT 0
`define CTRL_HALTED_BIT 1
`define NPINS 9
`define NSRC 12
`define SRC_NMI 8
`define SRC_TMR0 9
`define SRC_TMR1 10
`define SRC_EXP 11
`define TRIG_DEB_LSB 8

// ----------------------------------------------------------------------------
// Reset values and vector space
// ----------------------------------------------------------------------------
`define CTRL_RST 1'b0
`define MASK_RST 12'hfff
`define TRIG_RST 16'h0000
`define VEC_RST 8'h00
`define VEC_MIN 8'h08
`define VEC_MAX 8'hf7
`define NMI_VEC 8'hf8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define DEB_TIME_NS 1000
`define DEB_CYC ((`DEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEB_CNT_W 6

`endif

// ==== pin_sampler.sv ====
// Pin synchroniser with fast and debounced filtered levels
`timescale 1ns/10ps
`default_nettype none
`include "intake_regs.svh"
module pin_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic fast_q,
  output logic deb_q
);

  logic s1_q, s2_q, s3_q;
  logic fast_d, deb_d;
  logic [`DEB_CNT_W-1:0] cnt_q, cnt_d;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    fast_d = (s2_q == s3_q) ? s3_q : fast_q;
    deb_d = deb_q;
    cnt_d = '0;
    // Debounced level moves only after the pin stayed at the new value long enough
    if ((s2_q == s3_q) && (s3_q != deb_q)) begin
      if (cnt_q == `DEB_CNT_W'(`DEB_CYC - 1)) begin
        deb_d = s3_q;
      end else begin
        cnt_d = cnt_q + `DEB_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      fast_q <= 1'b0;
      deb_q <= 1'b0;
      cnt_q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fast_q <= fast_d;
      deb_q <= deb_d;
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// ==== tb_external_interrupt_intake.sv ====
// Self-checking testbench of the interrupt intake
`timescale 1ns/10ps
`default_nettype none
`include "intake_regs.svh"
module tb_external_interrupt_intake;
  import intake_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic halt_enter = 1'b0;
  logic int_ack = 1'b0;
  logic exp_mode = 1'b0;
  logic nmi_req = 1'b0;
  reg_req_t bus_req = '0;
  logic [7:0] line_req = 8'h00;
  logic [7:0] vec = 8'h00;
  logic [1:0] tmr_evt = 2'h0;
  logic [31:0] rd_data_q;
  irq_req_t core_irq_q;
  logic irq_q, wake_q, halted_q, nmi_pin;
  logic [7:0] irq_pins;
  int errors = 0;
  int comparisons = 0;
  int k;
  logic [7:0] va, vb;
  logic [31:0] d;

  always #12.5 clk = ~clk;

  ext_requesters i_ext_requesters (.clk(clk), .exp_mode(exp_mode), .line_req(line_req),
    .vec(vec), .nmi_req(nmi_req), .irq_pins(irq_pins), .nmi_pin(nmi_pin));
  external_interrupt_intake i_external_interrupt_intake (.clk(clk), .rst_n(rst_n), .ce(ce),
    .bus_req(bus_req), .rd_data_q(rd_data_q), .irq_pins(irq_pins), .nmi_pin(nmi_pin),
    .tmr_evt(tmr_evt), .halt_enter(halt_enter), .int_ack(int_ack), .core_irq_q(core_irq_q),
    .irq_q(irq_q), .wake_q(wake_q), .halted_q(halted_q));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    bus_req <= '{a, dat, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 dat = rd_data_q;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task ack();
    @(posedge clk);
    int_ack <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    #1;
  endtask
  task halt();
    @(posedge clk);
    halt_enter <= 1'b1;
    @(posedge clk);
    halt_enter <= 1'b0;
    cyc(1);
  endtask
  // Bounded waits: a hang here becomes a mismatch, not a stuck run
  task wait_irq(input logic lvl, input int n);
    for (int i = 0; i < n && irq_q !== lvl; i++) cyc(1);
    chk({31'h0, irq_q}, {31'h0, lvl});
  endtask
  task wait_wake(input int n);
    for (int i = 0; i < n && wake_q !== 1'b1; i++) cyc(1);
    chk({31'h0, wake_q}, 32'h1);
  endtask
  function automatic logic [7:0] rand_vec();
    return 8'h08 + 8'($urandom % 240);
  endfunction
  function automatic logic [7:0] winner(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic [31:0] irq_word(input logic [7:0] v);
    return {23'h0, 1'b1, v};
  endfunction
  task wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(65573));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFF_MASK, d); chk(d, 32'h0eff);
    rd(`OFF_CTRL, d); chk(d, 32'h0);
    rd(8'h20, d); chk(d, 32'h0);
    // Edge, fast sampling on a random pin; ack clears it although the pin stays high
    k = $urandom % 8;
    va = rand_vec();
    wr((k < 4) ? `OFF_VEC_LO : `OFF_VEC_HI, {24'h0, va} << (8 * (k % 4)));
    wr(`OFF_TRIG, 32'h1 << k);
    wr(`OFF_MASK, ~(32'h1 << k) & 32'hfff);
    @(posedge clk) line_req <= 8'h01 << k;
    wait_irq(1'b1, 20);
    chk({23'h0, core_irq_q}, irq_word(va));
    rd(`OFF_STATUS, d); chk(d, 32'h1 << k);
    ack();
    wait_irq(1'b0, 5);
    // Level mode re-raises while the pin is high, even after a clear
    wr(`OFF_TRIG, 32'h0);
    wait_irq(1'b1, 10);
    wr(`OFF_STATUS, 32'hfff);
    cyc(3); chk({31'h0, irq_q}, 32'h1);
    wr(`OFF_MASK, 32'hfff);
    cyc(20); chk({31'h0, irq_q}, 32'h0);
    @(posedge clk) line_req <= 8'h00;
    cyc(10);
    wr(`OFF_STATUS, 32'hfff);
    // Two pins at once: larger vector first, then the other
    va = rand_vec();
    vb = rand_vec();
    if (vb == va) vb = va ^ 8'h01;
    wr(`OFF_VEC_LO, {16'h0, vb, va});
    wr(`OFF_TRIG, 32'h3);
    wr(`OFF_MASK, 32'hffc);
    @(posedge clk) line_req <= 8'h03;
    wait_irq(1'b1, 20);
    chk({23'h0, core_irq_q}, irq_word(winner(va, vb)));
    rd(`OFF_ACTIVE, d); chk(d, {19'h0, (va > vb) ? 4'h0 : 4'h1, 1'b1, winner(va, vb)});
    ack(); cyc(2);
    chk({23'h0, core_irq_q}, irq_word((va > vb) ? vb : va));
    ack();
    @(posedge clk) line_req <= 8'h00;
    // Halt, then both timers wake the core
    va = rand_vec();
    vb = rand_vec();
    if (vb == va) vb = va ^ 8'h01;
    wr(`OFF_TVEC, {16'h0, vb, va});
    rd(`OFF_TVEC, d); chk(d, {16'h0, vb, va});
    wr(`OFF_MASK, 32'h9ff);
    wr(`OFF_STATUS, 32'hfff);
    halt(); chk({31'h0, halted_q}, 32'h1);
    rd(`OFF_CTRL, d); chk(d, 32'h2);
    @(posedge clk) tmr_evt <= 2'h3;
    @(posedge clk) tmr_evt <= 2'h0;
    wait_wake(10);
    cyc(1); chk({31'h0, halted_q}, 32'h0);
    chk({23'h0, core_irq_q}, irq_word(winner(va, vb)));
    ack(); cyc(2);
    chk({23'h0, core_irq_q}, irq_word((va > vb) ? vb : va));
    ack();
    // Non-maskable pin wakes a halted core with everything masked
    wr(`OFF_MASK, 32'hfff);
    rd(`OFF_MASK, d); chk(d, 32'h0eff);
    halt();
    // Frozen clock enable: the request waits in the pin until the block runs again
    @(posedge clk) ce <= 1'b0;
    nmi_req <= 1'b1;
    cyc(10); chk({30'h0, halted_q, wake_q}, 32'h2);
    @(posedge clk) ce <= 1'b1;
    wait_wake(20);
    cyc(1); chk({23'h0, core_irq_q}, irq_word(`NMI_VEC));
    ack();
    @(posedge clk) nmi_req <= 1'b0;
    cyc(8);
    wr(`OFF_STATUS, 32'hfff);
    // Expanded mode: out-of-range vector ignored, then a valid one taken
    va = rand_vec();
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_MASK, 32'h7ff);
    @(posedge clk) exp_mode <= 1'b1;
    vec <= 8'h03;
    cyc(20); chk({31'h0, irq_q}, 32'h0);
    @(posedge clk) vec <= va;
    wait_irq(1'b1, 20);
    chk({23'h0, core_irq_q}, irq_word(va));
    rd(`OFF_STATUS, d); chk(d, 32'h800);
    @(posedge clk) vec <= 8'h00;
    exp_mode <= 1'b0;
    wr(`OFF_CTRL, 32'h0);
    cyc(8);
    wr(`OFF_STATUS, 32'hfff);
    // Debounced edge: short glitch rejected, long level accepted
    k = $urandom % 8;
    wr(`OFF_TRIG, (32'h101) << k);
    wr(`OFF_MASK, ~(32'h1 << k) & 32'hfff);
    @(posedge clk) line_req <= 8'h01 << k;
    cyc(10);
    @(posedge clk) line_req <= 8'h00;
    cyc(60); chk({31'h0, irq_q}, 32'h0);
    @(posedge clk) line_req <= 8'h01 << k;
    cyc(30); chk({31'h0, irq_q}, 32'h0);
    wait_irq(1'b1, 30);
    @(posedge clk) line_req <= 8'h00;
    wrap_up();
  end
endmodule
`default_nettype wire
